// ---- epe_array_model.sv ----
// Row-delay model of the pixel analysis array feeding the detector
`timescale 1ns/1ps
module epe_array_model #(
    parameter int ROW_LEN = 8
) (
    // Clock, reset and serial pixel source
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] pix_in,
    input wire logic win_in,
    // Three in-phase row streams
    output logic [7:0] row_stream_current,
    output logic [7:0] row_stream_middle,
    output logic [7:0] row_stream_oldest,
    output logic window_active
);
    logic [2*ROW_LEN-1:0][7:0] line_ff;
    logic [ROW_LEN:0] win_ff;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            row_stream_current <= 8'h00;
            line_ff <= '0;
            win_ff <= '0;
        end else begin
            row_stream_current <= pix_in;
            line_ff <= {line_ff[2*ROW_LEN-2:0], row_stream_current};
            win_ff <= {win_ff[ROW_LEN-1:0], win_in};
        end
    end
    assign row_stream_middle = line_ff[ROW_LEN-1];
    assign row_stream_oldest = line_ff[2*ROW_LEN-1];
    // Window refers to the middle row, so it lags by one row
    assign window_active = win_ff[ROW_LEN];
endmodule : epe_array_model

// ---- epe_event_detect.sv ----
// Event peak validation, 3x3 energy and double-count flag behind AXI4-Lite
`timescale 1ns/1ps
module epe_event_detect #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Row streams and window
    input wire logic [epe_pkg::PIX_W-1:0] row_stream_current,
    input wire logic [epe_pkg::PIX_W-1:0] row_stream_middle,
    input wire logic [epe_pkg::PIX_W-1:0] row_stream_oldest,
    input wire logic window_active,
    // Event results
    output logic centre_strobe_tap_early,
    output logic centre_strobe_tap_mid,
    output logic centre_strobe_tap_late,
    output logic [epe_pkg::PIX_W-1:0] energy_value,
    output logic energy_overflow,
    output logic multi_hit_flag,
    output logic irq,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [epe_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [epe_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import epe_pkg::*;

    if (ADDR_W < REG_ADDR_MIN) begin : g_bad_addr
        $error("ADDR_W too small for the register map");
    end

    // Strictly above: value plus two's complement threshold passes 256
    function automatic logic above_thr(input logic [PIX_W-1:0] val,
                                       input logic [PIX_W-1:0] thr_cpl);
        logic [PIX_W:0] s;
        s = {1'b0, val} + {1'b0, thr_cpl};
        return s[PIX_W] && (s[PIX_W-1:0] != '0);
    endfunction : above_thr

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction : addr_is

    //--------------------------------------------------------------
    // AXI4-Lite slave
    //--------------------------------------------------------------
    logic aw_have_ff, w_have_ff, awready_ff, wready_ff, bvalid_ff;
    logic arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_fire, w_fire, wr_commit, wr_hit;
    logic [DATA_W-1:0] rd_word;
    logic rd_hit;

    assign aw_fire = s_axi_awvalid && awready_ff;
    assign w_fire = s_axi_wvalid && wready_ff;
    assign wr_commit = aw_have_ff && w_have_ff && !bvalid_ff;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            aw_have_ff <= 1'b0;
            awready_ff <= 1'b0;
            awaddr_ff <= '0;
        end else begin
            if (aw_fire) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_commit) begin
                aw_have_ff <= 1'b0;
            end
            awready_ff <= !(aw_fire || (aw_have_ff && !wr_commit));
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            w_have_ff <= 1'b0;
            wready_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (w_fire) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_commit) begin
                w_have_ff <= 1'b0;
            end
            wready_ff <= !(w_fire || (w_have_ff && !wr_commit));
        end
    end

    assign wr_hit = addr_is(awaddr_ff, ADDR_PEAK_THR) || addr_is(awaddr_ff, ADDR_ENERGY_THR)
        || addr_is(awaddr_ff, ADDR_CTRL) || addr_is(awaddr_ff, ADDR_IRQ_CLEAR)
        || addr_is(awaddr_ff, ADDR_IRQ_ENABLE);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    logic [PIX_W-1:0] peak_thr_ff, energy_thr_ff;
    logic multi_hit_enable_ff, lut_access_ff;
    logic [IRQ_W-1:0] irq_status_ff, irq_enable_ff, irq_set;
    logic peak_threshold_write_n, energy_threshold_write_n, lut_access_active_n;
    logic ctrl_bus_bit15;

    assign peak_threshold_write_n = !(wr_commit && addr_is(awaddr_ff, ADDR_PEAK_THR)
        && wstrb_ff[0]);
    assign energy_threshold_write_n = !(wr_commit && addr_is(awaddr_ff, ADDR_ENERGY_THR)
        && (wstrb_ff[0] || wstrb_ff[1]));
    assign ctrl_bus_bit15 = wdata_ff[ETHR_EN_BIT];
    assign lut_access_active_n = !lut_access_ff;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            peak_thr_ff <= PEAK_THR_RST;
        end else if (!peak_threshold_write_n) begin
            peak_thr_ff <= wdata_ff[PIX_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            energy_thr_ff <= ENERGY_THR_RST;
            multi_hit_enable_ff <= 1'b0;
        end else if (!energy_threshold_write_n) begin
            if (wstrb_ff[0]) begin
                energy_thr_ff <= wdata_ff[PIX_W-1:0];
            end
            if (wstrb_ff[1]) begin
                multi_hit_enable_ff <= ctrl_bus_bit15;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lut_access_ff <= 1'b0;
            irq_enable_ff <= '0;
        end else if (wr_commit && wstrb_ff[0]) begin
            if (addr_is(awaddr_ff, ADDR_CTRL)) begin
                lut_access_ff <= wdata_ff[CTRL_LUT_BIT];
            end
            if (addr_is(awaddr_ff, ADDR_IRQ_ENABLE)) begin
                irq_enable_ff <= wdata_ff[IRQ_W-1:0];
            end
        end
    end

    //--------------------------------------------------------------
    // Event validate
    //--------------------------------------------------------------
    logic [PIX_W-1:0] mid_d1_ff, mid_d2_ff, cur_d1_ff, old_d1_ff;
    logic centre_gt_prev_col_n, centre_ge_next_col, peak_hit_ff;
    logic [WIN_DLY-1:0] win_dly_ff;
    logic [STRB_LEN-1:0] strobe_sr_ff;
    logic event_centre_strobe;

    // Middle row holds the centre; the column before came a clock earlier
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mid_d1_ff <= '0;
            mid_d2_ff <= '0;
            cur_d1_ff <= '0;
            old_d1_ff <= '0;
        end else begin
            mid_d1_ff <= row_stream_middle;
            mid_d2_ff <= mid_d1_ff;
            cur_d1_ff <= row_stream_current;
            old_d1_ff <= row_stream_oldest;
        end
    end

    assign centre_gt_prev_col_n = !(mid_d1_ff > mid_d2_ff);
    assign centre_ge_next_col = mid_d1_ff >= row_stream_middle;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            peak_hit_ff <= 1'b0;
            win_dly_ff <= '0;
        end else begin
            peak_hit_ff <= !centre_gt_prev_col_n && centre_ge_next_col
                && (mid_d1_ff > cur_d1_ff) && (mid_d1_ff >= old_d1_ff)
                && above_thr(mid_d1_ff, peak_thr_ff);
            win_dly_ff <= {win_dly_ff[WIN_DLY-2:0], window_active};
        end
    end

    assign event_centre_strobe = peak_hit_ff && win_dly_ff[WIN_DLY-1];

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            strobe_sr_ff <= '0;
        end else begin
            strobe_sr_ff <= {strobe_sr_ff[STRB_LEN-2:0], event_centre_strobe}
                & {STRB_LEN{lut_access_active_n}};
        end
    end

    assign centre_strobe_tap_early = strobe_sr_ff[TAP_EARLY];
    assign centre_strobe_tap_mid = strobe_sr_ff[TAP_MID];
    assign centre_strobe_tap_late = strobe_sr_ff[TAP_LATE];

    //--------------------------------------------------------------
    // Event energy and double count
    //--------------------------------------------------------------
    logic [PIX_W:0] outer_rows_sum_ff;
    logic [PIX_W-1:0] mid_e_ff, energy_value_ff;
    logic [PIX_W+1:0] colsum_ff, col_first_ff;
    logic [PIX_W+2:0] two_column_sum_ff;
    logic [E_FULL_W-1:0] energy_full_ff;
    logic energy_overflow_ff, doub_ff, multi_hit_ff, irq_ff;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            outer_rows_sum_ff <= '0;
            mid_e_ff <= '0;
            colsum_ff <= '0;
            col_first_ff <= '0;
            two_column_sum_ff <= '0;
            energy_full_ff <= '0;
        end else begin
            outer_rows_sum_ff <= {1'b0, row_stream_current} + {1'b0, row_stream_oldest};
            mid_e_ff <= row_stream_middle;
            colsum_ff <= {1'b0, outer_rows_sum_ff} + {2'b00, mid_e_ff};
            col_first_ff <= colsum_ff;
            two_column_sum_ff <= {1'b0, colsum_ff} + {1'b0, col_first_ff};
            energy_full_ff <= {1'b0, two_column_sum_ff} + {2'b00, colsum_ff};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            energy_value_ff <= '0;
            energy_overflow_ff <= 1'b0;
            doub_ff <= 1'b0;
            multi_hit_ff <= 1'b0;
        end else begin
            energy_value_ff <= energy_full_ff[E_HI:E_LO];
            energy_overflow_ff <= |energy_full_ff[E_FULL_W-1:E_OVF_LO];
            doub_ff <= above_thr(energy_value_ff, energy_thr_ff) || energy_overflow_ff;
            multi_hit_ff <= doub_ff && strobe_sr_ff[TAP_DBL] && multi_hit_enable_ff;
        end
    end

    assign energy_value = energy_value_ff;
    assign energy_overflow = energy_overflow_ff;
    assign multi_hit_flag = multi_hit_ff;

    //--------------------------------------------------------------
    // Interrupts
    //--------------------------------------------------------------
    assign irq_set = {energy_overflow_ff && strobe_sr_ff[TAP_OVF], multi_hit_ff,
        strobe_sr_ff[TAP_EARLY]};

    // New events win over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq_status_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            if (wr_commit && wstrb_ff[0] && addr_is(awaddr_ff, ADDR_IRQ_CLEAR)) begin
                irq_status_ff <= (irq_status_ff & ~wdata_ff[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status_ff <= irq_status_ff | irq_set;
            end
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    assign irq = irq_ff;

    //--------------------------------------------------------------
    // Read channel
    //--------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (addr_is(s_axi_araddr, ADDR_PEAK_THR)) begin
            rd_word[PIX_W-1:0] = peak_thr_ff;
        end else if (addr_is(s_axi_araddr, ADDR_ENERGY_THR)) begin
            rd_word[PIX_W-1:0] = energy_thr_ff;
            rd_word[ETHR_EN_BIT] = multi_hit_enable_ff;
        end else if (addr_is(s_axi_araddr, ADDR_CTRL)) begin
            rd_word[CTRL_LUT_BIT] = lut_access_ff;
        end else if (addr_is(s_axi_araddr, ADDR_IRQ_STATUS)) begin
            rd_word[IRQ_W-1:0] = irq_status_ff;
        end else if (addr_is(s_axi_araddr, ADDR_IRQ_ENABLE)) begin
            rd_word[IRQ_W-1:0] = irq_enable_ff;
        end else if (addr_is(s_axi_araddr, ADDR_ENERGY)) begin
            rd_word[PIX_W-1:0] = energy_value_ff;
            rd_word[ENERGY_OVF_BIT] = energy_overflow_ff;
        end else if (!addr_is(s_axi_araddr, ADDR_IRQ_CLEAR)) begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    logic [3:0] warm_ff;
    logic [PIX_W+1:0] col_in;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            warm_ff <= '0;
        end else if (warm_ff != WARM_CYC) begin
            warm_ff <= warm_ff + 4'h1;
        end
    end

    assign col_in = (PIX_W+2)'(row_stream_current) + (PIX_W+2)'(row_stream_middle)
        + (PIX_W+2)'(row_stream_oldest);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_lut_blocks: assert property (lut_access_ff |=> !(centre_strobe_tap_early
        || centre_strobe_tap_mid || centre_strobe_tap_late)) else $error("strobe during lut");
    a_peak_shape: assert property ((warm_ff == WARM_CYC) && centre_strobe_tap_early |->
        ($past(row_stream_middle, 3) > $past(row_stream_middle, 4))
        && ($past(row_stream_middle, 3) >= $past(row_stream_middle, 2))
        && ($past(row_stream_middle, 3) > $past(row_stream_current, 3))
        && ($past(row_stream_middle, 3) >= $past(row_stream_oldest, 3)))
        else $error("strobe without peak shape");
    a_peak_window: assert property ((warm_ff == WARM_CYC) && centre_strobe_tap_early |->
        $past(window_active, 3) && $past(mid_d1_ff, 2) == $past(row_stream_middle, 3))
        else $error("strobe outside window or late");
    a_tap_shift: assert property (centre_strobe_tap_early && !lut_access_ff
        ##1 !lut_access_ff |=> centre_strobe_tap_mid) else $error("mid tap missing");
    a_strobe_pulse: assert property (centre_strobe_tap_early |=>
        !centre_strobe_tap_early) else $error("strobe longer than one clock");
    a_energy_sum: assert property ((warm_ff == WARM_CYC) |-> energy_value ==
        PIX_W'((E_FULL_W'($past(col_in, 4)) + E_FULL_W'($past(col_in, 5))
        + E_FULL_W'($past(col_in, 6))) >> E_LO)) else $error("energy value wrong");
    a_energy_ovf: assert property ((warm_ff == WARM_CYC) |-> energy_overflow ==
        ((E_FULL_W'($past(col_in, 4)) + E_FULL_W'($past(col_in, 5))
        + E_FULL_W'($past(col_in, 6))) >= E_FULL_W'(1 << E_OVF_LO)))
        else $error("overflow flag wrong");
    a_double_cause: assert property (multi_hit_flag |-> ($past(energy_overflow, 2)
        || above_thr($past(energy_value, 2), $past(energy_thr_ff, 2)))
        && $past(centre_strobe_tap_early, 4)) else $error("double without cause");
    a_double_enable: assert property (!multi_hit_enable_ff |=> !multi_hit_flag)
        else $error("double while disabled");
    a_enable_reset: assert property ($rose(rstn) |-> !multi_hit_enable_ff)
        else $error("double enable set after reset");
    a_peak_thr_load: assert property (!peak_threshold_write_n |=>
        peak_thr_ff == $past(wdata_ff[PIX_W-1:0])) else $error("peak threshold not loaded");
    a_bresp_hold: assert property (bvalid_ff && !s_axi_bready |=> bvalid_ff
        && $stable(bresp_ff)) else $error("write response dropped");

    c_event: cover property (centre_strobe_tap_late);
    c_double: cover property (multi_hit_flag);
    c_ovf_event: cover property (irq_status_ff[IRQ_OVF] && irq);
    c_write: cover property (bvalid_ff && s_axi_bready);
endmodule : epe_event_detect

// ---- epe_pkg.sv ----
// Constants and register map of the event peak and energy detect block
// Operation
// - Peak: centre beats prev column, ties next, beats one row, ties other, over threshold
// - Peak threshold is 8 bits, written by its own strobe, held two's complemented
// - Window active is delayed to match the peak pipeline and ANDed in
// - Final strobe runs through a shift register with three taps
// - Earliest tap rises 3 clocks after the peak sits at the centre element
// - Lookup table access forces every strobe tap low
// - Energy is the sum of the nine pixels around the centre, every clock
// - Outer rows add first with latched carry, middle row one stage later
// - First column sum latched, added to next, then third, carries build upper bits
// - Energy output is bits 2 to 9 of the full sum
// - Sum bits above 9 are ORed into the overflow flag
// - Energy comes 5 clocks after centring, double flag 2 clocks later
// - Energy is compared with an 8-bit two's complemented threshold from its own strobe
// - Threshold result ORed with overflow, then latched as the double flag
// - Energy threshold strobe also takes bus bit 15 as double enable
// - Double enable is off after reset
// - Oldest stream is two rows back, current stream is the present row
// - Columns arrive one per clock: first column, centre column, then last
package epe_pkg;
    localparam int PIX_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_ADDR_MIN = 5;
    // Register byte offsets
    localparam logic [7:0] ADDR_PEAK_THR = 8'h00;
    localparam logic [7:0] ADDR_ENERGY_THR = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_ENERGY = 8'h18;
    // Fields
    localparam int ETHR_EN_BIT = 15;
    localparam int CTRL_LUT_BIT = 0;
    localparam int ENERGY_OVF_BIT = 8;
    localparam int IRQ_EVT = 0;
    localparam int IRQ_DBL = 1;
    localparam int IRQ_OVF = 2;
    localparam int IRQ_W = 3;
    // Reset values
    localparam logic [7:0] PEAK_THR_RST = 8'h00;
    localparam logic [7:0] ENERGY_THR_RST = 8'h00;
    // Pipeline geometry
    localparam int WIN_DLY = 2;
    localparam int STRB_LEN = 5;
    localparam int TAP_EARLY = 0;
    localparam int TAP_MID = 2;
    localparam int TAP_LATE = 4;
    localparam int TAP_OVF = 2;
    localparam int TAP_DBL = 3;
    localparam int E_FULL_W = 12;
    localparam int E_LO = 2;
    localparam int E_HI = 9;
    localparam int E_OVF_LO = 10;
    localparam logic [3:0] WARM_CYC = 4'h8;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : epe_pkg

// ---- event_peak_and_energy_detect_tb_top.sv ----
// Self-checking bench for the event peak and energy detect block
`timescale 1ns/1ps
module event_peak_and_energy_detect_tb_top;
    import epe_pkg::*;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] pix_in = 8'h00;
    logic win_in = 1'h0;
    logic [7:0] row_stream_current, row_stream_middle, row_stream_oldest, energy_value;
    logic window_active, centre_strobe_tap_early, centre_strobe_tap_mid, centre_strobe_tap_late;
    logic energy_overflow, multi_hit_flag, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] rst_regs[7] = '{ADDR_PEAK_THR, ADDR_ENERGY_THR, ADDR_CTRL, ADDR_IRQ_STATUS,
        ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE, ADDR_ENERGY};
    int err_total = 0, cmp_count = 0, quiet = 12, hits = 0, pw = 256, ew = 256;
    bit den = 0, lut = 0;
    int hc[10], hm[10], ho[10], hw[10];

    always #50 mclk = ~mclk;
    epe_array_model #(.ROW_LEN(8)) array_u (.*);
    epe_event_detect dut_u (.*);

    // ----------------------------------------
    // Reference model and checks
    // ----------------------------------------
    function automatic int esum(int j);
        return hc[j-1] + hm[j-1] + ho[j-1] + hc[j] + hm[j] + ho[j] + hc[j+1] + hm[j+1] + ho[j+1];
    endfunction : esum
    function automatic bit pk(int j);
        return hm[j] > hm[j+1] && hm[j] >= hm[j-1] && hm[j] > hc[j] && hm[j] >= ho[j]
            && hm[j] > pw && hw[j] == 1 && !lut;
    endfunction : pk
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    always @(posedge mclk) begin
        for (int i = 9; i > 0; i--) begin
            hc[i] = hc[i-1];
            hm[i] = hm[i-1];
            ho[i] = ho[i-1];
            hw[i] = hw[i-1];
        end
        hc[0] = row_stream_current;
        hm[0] = row_stream_middle;
        ho[0] = row_stream_oldest;
        hw[0] = window_active;
        if (quiet > 0) begin
            quiet--;
        end else begin
            chk(energy_value, (esum(5) >> 2) & 255);
            chk(energy_overflow, esum(5) >= 1024);
            chk(centre_strobe_tap_early, pk(3));
            chk(centre_strobe_tap_mid, pk(5));
            chk(centre_strobe_tap_late, pk(7));
            chk(multi_hit_flag, pk(7) && den && ((esum(7) >> 2) % 256 > ew || esum(7) >= 1024));
            hits += pk(3);
        end
    end

    // ----------------------------------------
    // Bus and stream drivers
    // ----------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        quiet = 14;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'h0;
        quiet = 14;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'h0;
    endtask : axi_rd
    task automatic set_thr(int p, int e, bit en);
        pw = p;
        ew = e;
        den = en;
        axi_wr(ADDR_PEAK_THR, (256 - p) & 255, 4'hf, RESP_OKAY);
        axi_wr(ADDR_ENERGY_THR, ((256 - e) & 255) | (en << 15), 4'hf, RESP_OKAY);
        axi_rd(ADDR_ENERGY_THR, ((256 - e) & 255) | (en << 15), RESP_OKAY);
    endtask : set_thr
    task automatic feed(int n, logic [7:0] m);
        repeat (n) begin
            @(posedge mclk);
            pix_in <= 8'($urandom & m);
            win_in <= 1'($urandom % 2);
        end
    endtask : feed
    task automatic put_event(int b, bit w);
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 8; c++) begin
                @(posedge mclk);
                pix_in <= 8'((r == 1 && c > 2 && c < 5) || (r == 0 && c == 3) ? b :
                    (c == 3 || (r == 1 && c == 2)) ? b - 1 : 0);
                win_in <= w && r == 1 && c == 3;
            end
        end
        feed(16, 8'h00);
    endtask : put_event
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'haa27_6da8));
        repeat (2) @(posedge mclk);
        rstn <= 1'h1;
        foreach (rst_regs[i]) axi_rd(rst_regs[i], 32'h0000_0000, RESP_OKAY);
        axi_rd(8'h1c, 32'h0000_0000, RESP_SLVERR);
        axi_wr(ADDR_ENERGY, 32'h0000_00ff, 4'hf, RESP_SLVERR);
        set_thr(100, 124, 1);
        axi_wr(ADDR_IRQ_CLEAR, 32'h0000_0007, 4'hf, RESP_OKAY);
        put_event(100, 1);
        put_event(101, 0);
        put_event(101, 1);
        axi_rd(ADDR_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
        chk(irq, 1'h0);
        axi_wr(ADDR_IRQ_ENABLE, 32'h0000_0003, 4'hf, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 1'h1);
        axi_wr(ADDR_IRQ_CLEAR, 32'h0000_0007, 4'hf, RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 1'h0);
        set_thr(100, 125, 1);
        put_event(101, 1);
        set_thr(100, 124, 0);
        axi_wr(ADDR_ENERGY_THR, 32'h0000_8084, 4'h1, RESP_OKAY);
        axi_rd(ADDR_ENERGY_THR, 32'h0000_0084, RESP_OKAY);
        put_event(101, 1);
        lut = 1;
        axi_wr(ADDR_CTRL, 32'h0000_0001, 4'hf, RESP_OKAY);
        put_event(101, 1);
        lut = 0;
        axi_wr(ADDR_CTRL, 32'h0000_0000, 4'hf, RESP_OKAY);
        for (int k = 0; k < 6; k++) begin
            set_thr(1 + $urandom % 255, 1 + $urandom % 255, 1'($urandom % 2));
            feed(400, k[0] ? 8'hff : 8'h3f);
        end
        chk(hits != 0, 1'h1);
        wrap_up();
    end
endmodule : event_peak_and_energy_detect_tb_top
